/* File: inc/wwd_pkg.sv */
`default_nettype none
package wwd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] WWD_OFS_CTRL = 8'h00;
  localparam logic [7:0] WWD_OFS_STAT = 8'h04;
  localparam logic [7:0] WWD_OFS_MASK = 8'h08;
  localparam logic [7:0] WWD_OFS_CLKSEL = 8'h0C;
  localparam logic [7:0] WWD_OFS_INT_LATE = 8'h10;
  localparam logic [7:0] WWD_OFS_RST_LATE = 8'h14;
  localparam logic [7:0] WWD_OFS_INT_EARLY = 8'h18;
  localparam logic [7:0] WWD_OFS_RST_EARLY = 8'h1C;
  localparam logic [7:0] WWD_OFS_COUNT = 8'h20;
  localparam logic [7:0] WWD_OFS_FEED = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts: bit 0 of each struct is the lowest register bit
  typedef struct packed {
    logic rst_en;
    logic int_en;
    logic win_en;
    logic en;
  } wwd_ctrl_t;

  typedef struct packed {
    logic rst_late;
    logic int_late;
    logic rst_early;
    logic int_early;
  } wwd_evt_t;

  // Pending first key of a two-write sequence
  typedef enum logic [1:0] {
    WWD_PEND_NONE,
    WWD_PEND_FEED,
    WWD_PEND_EN,
    WWD_PEND_DIS
  } wwd_pend_t;

  ////////////////////////////////////////////////////////////////////////////
  // Limit floor and reset values
  localparam logic [31:0] WWD_LIMIT_MIN = 32'h0001_0000;
  localparam wwd_ctrl_t WWD_CTRL_RST = 4'h0;
  localparam wwd_evt_t WWD_EVT_RST = 4'h0;
  localparam logic [2:0] WWD_CLKSEL_RST = 3'h0;
  localparam logic [31:0] WWD_INT_LATE_RST = 32'h8000_0000;
  localparam logic [31:0] WWD_RST_LATE_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] WWD_INT_EARLY_RST = 32'h0001_0000;
  localparam logic [31:0] WWD_RST_EARLY_RST = 32'h0001_0000;
  localparam logic [31:0] WWD_COUNT_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Keys written to the feed key register
  localparam logic [7:0] WWD_KEY_FEED1 = 8'hA5;
  localparam logic [7:0] WWD_KEY_FEED2 = 8'h5A;
  localparam logic [7:0] WWD_KEY_EN1 = 8'hFE;
  localparam logic [7:0] WWD_KEY_EN2 = 8'hED;
  localparam logic [7:0] WWD_KEY_DIS1 = 8'hDE;
  localparam logic [7:0] WWD_KEY_DIS2 = 8'hAD;

  // Time-base selects: 0 is the bus clock itself, 7 is reserved
  localparam logic [2:0] WWD_SEL_PCLK = 3'h0;
  localparam logic [2:0] WWD_SEL_RSVD = 3'h7;
  localparam int unsigned WWD_NUM_PIN_SRC = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for APB writes with pstrb
  function automatic logic [31:0] wwd_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : wwd_merge

  // Limits never go below the smallest legal threshold
  function automatic logic [31:0] wwd_clamp(input logic [31:0] v);
    return (v < WWD_LIMIT_MIN) ? WWD_LIMIT_MIN : v;
  endfunction : wwd_clamp

endpackage : wwd_pkg
`default_nettype wire

/* File: rtl/wwd_tick_sel.sv */
`timescale 1ns/1ns
`default_nettype none
module wwd_tick_sel
  import wwd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] sel,
  input wire logic [WWD_NUM_PIN_SRC-1:0] src_in,
  output logic tick
);

  logic [WWD_NUM_PIN_SRC-1:0] sync1_r;
  logic [WWD_NUM_PIN_SRC-1:0] sync2_r;
  logic prev_r;
  logic tick_r;
  wire logic [2:0] pin_idx;
  wire logic pin_ok;
  wire logic lvl;
  wire logic tick_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers on every asynchronous source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= src_in;
      sync2_r <= sync1_r;
    end
  end

  // Source select; a select change may give one stray tick, harmless
  assign pin_ok = (sel != WWD_SEL_PCLK) && (sel != WWD_SEL_RSVD);
  assign pin_idx = sel - 3'h1;
  assign lvl = pin_ok ? sync2_r[pin_idx] : 1'b0;
  assign tick_nxt = (sel == WWD_SEL_PCLK) ? 1'b1 : (lvl & ~prev_r);

  // Rising-edge detect; sources must run below a quarter of pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      prev_r <= lvl;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  a_rsvd_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == WWD_SEL_RSVD) && $stable(sel) |=> !tick)
    else $error("reserved time base produced a tick");

endmodule : wwd_tick_sel
`default_nettype wire

/* File: rtl/wwd_top.sv */
`timescale 1ns/1ns
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_rst,
  input wire logic periph_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WWD_NUM_PIN_SRC-1:0] src_clk_in,
  output logic irq,
  output logic wake_req,
  output logic sys_reset_req
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wwd_ctrl_t watchdog_control_r;
  wwd_ctrl_t watchdog_control_nxt;
  wwd_evt_t stat_r;
  wwd_evt_t stat_nxt;
  wwd_evt_t mask_r;
  wwd_evt_t evt;
  wwd_evt_t stat_clr;
  wwd_evt_t irq_gate;
  wwd_pend_t pend_r;
  wwd_pend_t pend_nxt;
  logic [2:0] clksel_r;
  logic [31:0] int_late_r;
  logic [31:0] rst_late_r;
  logic [31:0] int_early_r;
  logic [31:0] rst_early_r;
  logic [31:0] watchdog_counter_r;
  logic [31:0] watchdog_counter_nxt;
  logic [31:0] prdata_r;
  logic irq_r;
  logic sys_reset_req_r;
  wire logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, so the access phase is always the last
  wire logic acc = psel & penable;
  wire logic wr_acc = acc & pwrite;
  wire logic rd_acc = acc & ~pwrite;
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic hit_ctrl = (paddr == WWD_OFS_CTRL);
  wire logic hit_stat = (paddr == WWD_OFS_STAT);
  wire logic hit_mask = (paddr == WWD_OFS_MASK);
  wire logic hit_clksel = (paddr == WWD_OFS_CLKSEL);
  wire logic hit_il = (paddr == WWD_OFS_INT_LATE);
  wire logic hit_rl = (paddr == WWD_OFS_RST_LATE);
  wire logic hit_ie = (paddr == WWD_OFS_INT_EARLY);
  wire logic hit_re = (paddr == WWD_OFS_RST_EARLY);
  wire logic hit_cnt = (paddr == WWD_OFS_COUNT);
  wire logic hit_feed = (paddr == WWD_OFS_FEED);
  wire logic addr_ok = hit_ctrl | hit_stat | hit_mask | hit_clksel | hit_il | hit_rl
    | hit_ie | hit_re | hit_cnt | hit_feed;

  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign prdata = prdata_r;

  // Read mux; the feed key register reads as zero
  wire logic [31:0] rd_mux =
    hit_ctrl ? {28'h0, watchdog_control_r} :
    hit_stat ? {28'h0, stat_r} :
    hit_mask ? {28'h0, mask_r} :
    hit_clksel ? {29'h0, clksel_r} :
    hit_il ? int_late_r :
    hit_rl ? rst_late_r :
    hit_ie ? int_early_r :
    hit_re ? rst_early_r :
    hit_cnt ? watchdog_counter_r : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Key sequencer for the feed key register
  wire logic key_wr = wr_acc & hit_feed & pstrb[0];
  wire logic [7:0] key = pwdata[7:0];
  wire logic feed_done = key_wr & (pend_r == WWD_PEND_FEED) & (key == WWD_KEY_FEED2);
  wire logic en_set = key_wr & (pend_r == WWD_PEND_EN) & (key == WWD_KEY_EN2);
  wire logic en_clr = key_wr & (pend_r == WWD_PEND_DIS) & (key == WWD_KEY_DIS2);

  // A feed pair may not have a write to another register between; enable and disable pairs may be spread
  always_comb
  begin
    pend_nxt = pend_r;
    case (pend_r)
      WWD_PEND_NONE, WWD_PEND_EN, WWD_PEND_DIS:
        pend_nxt = pend_r;
      WWD_PEND_FEED:
        if (wr_acc && !hit_feed)
          pend_nxt = WWD_PEND_NONE;
      default:
        pend_nxt = WWD_PEND_NONE;
    endcase
    if (key_wr)
    begin
      if (key == WWD_KEY_FEED1)
        pend_nxt = WWD_PEND_FEED;
      else if (key == WWD_KEY_EN1)
        pend_nxt = WWD_PEND_EN;
      else if (key == WWD_KEY_DIS1)
        pend_nxt = WWD_PEND_DIS;
      else
        pend_nxt = WWD_PEND_NONE;
    end
    if (periph_rst)
      pend_nxt = WWD_PEND_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and events
  wire logic tick_en = watchdog_control_r.en & tick;
  wire logic [31:0] cnt_inc = watchdog_counter_r + 32'h1;
  wire logic late_int_hit = tick_en & (cnt_inc == int_late_r);
  wire logic late_rst_hit = tick_en & (cnt_inc == rst_late_r);
  wire logic early_rst_hit = feed_done & (watchdog_counter_r < rst_early_r);
  wire logic early_int_hit = feed_done & ~early_rst_hit
    & (watchdog_counter_r < int_early_r);
  wire logic reset_fire = watchdog_control_r.rst_en
    & (late_rst_hit | (early_rst_hit & watchdog_control_r.win_en));

  // Flags set regardless of enables; the window only gates the actions
  assign evt = {late_rst_hit, late_int_hit, early_rst_hit, early_int_hit};

  // Feed, reset request or system reset return the count to zero
  always_comb
  begin
    watchdog_counter_nxt = watchdog_counter_r;
    if (sys_rst || feed_done || reset_fire)
      watchdog_counter_nxt = WWD_COUNT_RST;
    else if (tick_en)
      watchdog_counter_nxt = cnt_inc;
  end

  // Read clears only the bits that the read returned, so a new event wins
  assign stat_clr = (rd_acc && hit_stat) ? wwd_evt_t'(prdata_r[3:0]) : WWD_EVT_RST;
  assign stat_nxt = (stat_r & ~stat_clr) | evt;

  // Early events only interrupt with the window on; int_en gates all
  assign irq_gate = {1'b1, 1'b1, watchdog_control_r.win_en, watchdog_control_r.win_en};
  wire logic irq_nxt = watchdog_control_r.int_en & |(stat_r & mask_r & irq_gate);

  always_comb
  begin
    watchdog_control_nxt = watchdog_control_r;
    if (wr_acc && hit_ctrl && pstrb[0])
    begin
      watchdog_control_nxt.win_en = pwdata[1];
      watchdog_control_nxt.int_en = pwdata[2];
      watchdog_control_nxt.rst_en = pwdata[3];
    end
    if (en_set)
      watchdog_control_nxt.en = 1'b1;
    else if (en_clr)
      watchdog_control_nxt.en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State flops: presetn (power-on) clears them all; periph_rst clears only pend_r, sys_rst only the counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_control_r <= WWD_CTRL_RST;
      stat_r <= WWD_EVT_RST;
      pend_r <= WWD_PEND_NONE;
      watchdog_counter_r <= WWD_COUNT_RST;
      irq_r <= 1'b0;
      sys_reset_req_r <= 1'b0;
    end
    else
    begin
      watchdog_control_r <= watchdog_control_nxt;
      stat_r <= stat_nxt;
      pend_r <= pend_nxt;
      watchdog_counter_r <= watchdog_counter_nxt;
      irq_r <= irq_nxt;
      sys_reset_req_r <= reset_fire;
    end
  end

  // Configuration registers, limits clamped to the legal range
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_r <= WWD_EVT_RST;
      clksel_r <= WWD_CLKSEL_RST;
      int_late_r <= WWD_INT_LATE_RST;
      rst_late_r <= WWD_RST_LATE_RST;
      int_early_r <= WWD_INT_EARLY_RST;
      rst_early_r <= WWD_RST_EARLY_RST;
    end
    else if (wr_acc)
    begin
      if (hit_mask && pstrb[0])
        mask_r <= wwd_evt_t'(pwdata[3:0]);
      if (hit_clksel && pstrb[0])
        clksel_r <= pwdata[2:0];
      if (hit_il)
        int_late_r <= wwd_clamp(wwd_merge(int_late_r, pwdata, pstrb));
      if (hit_rl)
        rst_late_r <= wwd_clamp(wwd_merge(rst_late_r, pwdata, pstrb));
      if (hit_ie)
        int_early_r <= wwd_clamp(wwd_merge(int_early_r, pwdata, pstrb));
      if (hit_re)
        rst_early_r <= wwd_clamp(wwd_merge(rst_early_r, pwdata, pstrb));
    end
  end

  // Read data captured in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0;
    else if (rd_setup)
      prdata_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base and outputs
  wwd_tick_sel u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .sel(clksel_r),
    .src_in(src_clk_in),
    .tick(tick)
  );

  assign irq = irq_r;
  assign wake_req = irq_r;
  assign sys_reset_req = sys_reset_req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_early_flag;
    stat_r.int_early;
  endsequence

  sequence s_early_irq;
    irq;
  endsequence

  a_count_step: assert property (tick_en && !feed_done && !reset_fire && !sys_rst
    |=> watchdog_counter_r == $past(watchdog_counter_r) + 32'h1)
    else $error("counter did not advance on tick");

  a_feed_zero: assert property (feed_done |=> watchdog_counter_r == 32'h0)
    else $error("feed did not clear counter");

  a_late_int_flag: assert property (late_int_hit |=> stat_r.int_late)
    else $error("late interrupt flag missing");

  a_late_reset: assert property (late_rst_hit && watchdog_control_r.rst_en
    |=> sys_reset_req && watchdog_counter_r == 32'h0 ##1 !sys_reset_req)
    else $error("late reset not a single pulse");

  a_early_int_irq: assert property (early_int_hit && watchdog_control_r.win_en
    && watchdog_control_r.int_en && mask_r.int_early && !(rd_acc && hit_stat)
    |=> s_early_flag ##1 s_early_irq)
    else $error("early interrupt not raised");

  a_early_reset: assert property (feed_done && watchdog_counter_r < rst_early_r
    && watchdog_control_r.win_en && watchdog_control_r.rst_en |=> sys_reset_req)
    else $error("early reset not requested");

  a_flag_nowin: assert property (early_rst_hit && !watchdog_control_r.win_en
    |=> stat_r.rst_early && !sys_reset_req)
    else $error("early flag wrong with window off");

  a_limit_floor: assert property (int_late_r >= WWD_LIMIT_MIN && rst_late_r >= WWD_LIMIT_MIN
    && int_early_r >= WWD_LIMIT_MIN && rst_early_r >= WWD_LIMIT_MIN)
    else $error("limit below minimum");

  a_periph_keep: assert property (periph_rst && !wr_acc |=> $stable(watchdog_control_r))
    else $error("peripheral reset changed control");

  a_enable_pair: assert property (en_set |=> watchdog_control_r.en)
    else $error("enable pair did not enable");

  a_disable_pair: assert property (en_clr |=> !watchdog_control_r.en)
    else $error("disable pair did not disable");

  a_lone_key: assert property (key_wr && pend_r == WWD_PEND_NONE
    |-> !feed_done && !en_set && !en_clr)
    else $error("second key acted without first key");

endmodule : wwd_top
`default_nettype wire

/* File: dv/windowed_watchdog_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer_test
  import wwd_pkg::*;
;
  logic pclk, presetn, sys_rst, periph_rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lim;
  logic [3:0] pstrb;
  logic pready, pslverr, irq, wake_req, sys_reset_req;
  logic [WWD_NUM_PIN_SRC-1:0] src_clk_in;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int bad_count, tests_run, cyc, rst_pulses, n;

  wwd_top i_dut (.pclk(pclk), .presetn(presetn), .sys_rst(sys_rst), .periph_rst(periph_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_clk_in(src_clk_in), .irq(irq), .wake_req(wake_req), .sys_reset_req(sys_reset_req));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time-base pins, pins kept well below a quarter of pclk
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc[1:0] == 2'h0)
      src_clk_in <= src_clk_in + 6'h01;
    if (sys_reset_req === 1'b1)
      rst_pulses <= rst_pulses + 1;
    if (cyc > 90000)
    begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task automatic test_done();
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Read monitor: oldest note is matched against each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = exp_q.pop_front();
      // Error flag is checked on every read, mapped offsets included
      check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (!e[32])
        check("prdata", prdata, e[31:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB master; an idle cycle follows so psel is never assigned twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back({1'b0, x});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic key(input logic [7:0] k);
    wr(WWD_OFS_FEED, {24'h0, k});
  endtask : key

  task automatic feed();
    key(WWD_KEY_FEED1);
    key(WWD_KEY_FEED2);
  endtask : feed

  task automatic settle_irq(input logic x);
    repeat (3) @(posedge pclk);
    check("irq", {31'h0, irq}, {31'h0, x});
  endtask : settle_irq

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {presetn, sys_rst, periph_rst, psel, penable, pwrite} = 6'h00;
    {paddr, pwdata, pstrb, src_clk_in} = '0;
    {bad_count, tests_run, cyc, rst_pulses} = '0;
    void'($urandom(32'h25123D0C));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped offset
    rd(WWD_OFS_CTRL, 32'h0);
    rd(WWD_OFS_STAT, 32'h0);
    rd(WWD_OFS_MASK, 32'h0);
    rd(WWD_OFS_INT_LATE, 32'h8000_0000);
    rd(WWD_OFS_RST_LATE, 32'hFFFF_FFFF);
    rd(WWD_OFS_INT_EARLY, 32'h0001_0000);
    rd(WWD_OFS_RST_EARLY, 32'h0001_0000);
    rd(WWD_OFS_COUNT, 32'h0);
    rd(WWD_OFS_FEED, 32'h0);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h30, 32'h0);
    // Second keys alone must do nothing
    key(WWD_KEY_FEED2);
    key(WWD_KEY_EN2);
    rd(WWD_OFS_CTRL, 32'h0);
    // Enable pair with another register written between
    key(WWD_KEY_EN1);
    wr(WWD_OFS_MASK, 32'h0);
    key(WWD_KEY_EN2);
    rd(WWD_OFS_CTRL, 32'h1);
    // Early feed with window, interrupt and reset enables off still flags, then read clears
    feed();
    rd(WWD_OFS_STAT, 32'h2);
    rd(WWD_OFS_STAT, 32'h0);
    // Broken feed pair must not count as a feed
    key(WWD_KEY_FEED1);
    wr(WWD_OFS_MASK, 32'h0);
    key(WWD_KEY_FEED2);
    rd(WWD_OFS_STAT, 32'h0);
    // Disable pair then enable again
    key(WWD_KEY_DIS1);
    wr(WWD_OFS_CLKSEL, 32'h0);
    key(WWD_KEY_DIS2);
    rd(WWD_OFS_CTRL, 32'h0);
    key(WWD_KEY_EN1);
    key(WWD_KEY_EN2);
    // Every time-base select is accepted, reserved one included
    for (int s = 7; s >= 0; s--)
    begin
      wr(WWD_OFS_CLKSEL, s);
      rd(WWD_OFS_CLKSEL, s);
    end
    // Reserved time base must never advance the counter after a feed
    wr(WWD_OFS_CLKSEL, 32'h7);
    feed();
    repeat (8) @(posedge pclk);
    rd(WWD_OFS_COUNT, 32'h0);
    wr(WWD_OFS_CLKSEL, 32'h0);
    // Limits: random legal values, then a value below the floor
    for (int i = 0; i < 4; i++)
    begin
      lim = $urandom() | 32'h0001_0000;
      wr(WWD_OFS_INT_LATE + 8'(4 * i), lim);
      rd(WWD_OFS_INT_LATE + 8'(4 * i), lim);
    end
    wr(WWD_OFS_INT_EARLY, 32'h0000_0005);
    rd(WWD_OFS_INT_EARLY, 32'h0001_0000);
    // Late events then a feed inside the early window
    wr(WWD_OFS_INT_LATE, 32'h0001_0008);
    wr(WWD_OFS_RST_LATE, 32'h0001_0004);
    wr(WWD_OFS_INT_EARLY, 32'h0001_0020);
    wr(WWD_OFS_RST_EARLY, 32'h0001_0000);
    // Mask enables late and early interrupt flags only, not the reset flags
    wr(WWD_OFS_MASK, 32'h5);
    wr(WWD_OFS_CTRL, 32'h6);
    feed();
    rd(WWD_OFS_STAT, 32'h2);
    n = 0;
    // Sampled on the falling edge, away from the edge that launches irq
    while (irq !== 1'b1 && n < 70000)
    begin
      @(negedge pclk);
      n++;
    end
    check("late irq time", 32'(n >= 32'h0000_FFF8 && n <= 32'h0001_0008), 32'h1);
    check("wake", {31'h0, wake_req}, 32'h1);
    @(posedge pclk);
    feed();
    rd(WWD_OFS_STAT, 32'hD);
    settle_irq(1'b0);
    // Early reset flag stays off irq until its mask bit is set, read clears it
    wr(WWD_OFS_MASK, 32'hD);
    feed();
    settle_irq(1'b0);
    wr(WWD_OFS_MASK, 32'h2);
    settle_irq(1'b1);
    rd(WWD_OFS_STAT, 32'h2);
    settle_irq(1'b0);
    check("no reset", rst_pulses, 32'h0);
    // Early reset with reset enabled, then lesser and system resets
    wr(WWD_OFS_CTRL, 32'hA);
    feed();
    repeat (4) @(posedge pclk);
    check("reset pulse", rst_pulses, 32'h1);
    sys_rst <= 1'b1;
    periph_rst <= 1'b1;
    @(posedge pclk);
    sys_rst <= 1'b0;
    periph_rst <= 1'b0;
    @(posedge pclk);
    rd(WWD_OFS_CTRL, 32'hB);
    rd(WWD_OFS_STAT, 32'h2);
    repeat (4) @(posedge pclk);
    check("queue", exp_q.size(), 32'h0);
    test_done();
  end
endmodule : windowed_watchdog_timer_test
`default_nettype wire
